// file: logic/ssi_encoder_map.vh
`ifndef SSI_ENCODER_MAP_VH
`define SSI_ENCODER_MAP_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS        40
`define LINE_RELEASE_US      25
`define LINE_RELEASE_CYCLES  ((`LINE_RELEASE_US * 1000) / `CLK_PERIOD_NS)
`define UPDATE_RATE_KHZ      35
`define UPDATE_FAST_KHZ      375
`define UPDATE_CYCLES        ((1000000 / `UPDATE_RATE_KHZ) / `CLK_PERIOD_NS)
`define UPDATE_FAST_CYCLES   ((1000000 / `UPDATE_FAST_KHZ) / `CLK_PERIOD_NS)
`define INTER_FRAME_PAUSE_US 26
// ----------------------------------------
// Frame layout
// ----------------------------------------
`define POS_BITS             16
`define FIFO_DEPTH           32
`define ERR_FLAG_OK          1'h0
`define ERR_FLAG_FAIL        1'h1
`endif

// file: logic/sample_fifo.v
`timescale 1ns/100ps
module sample_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             mclk_in,
  input  wire             rst_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  input  wire [WIDTH-1:0] wr_data_in,
  output wire             rd_valid_out,
  input  wire             rd_ready_in,
  output wire [WIDTH-1:0] rd_data_out
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            do_wr;
  wire            do_rd;

  function [AW-1:0] next_ptr;
    input [AW-1:0] ptr;
    begin
      next_ptr = (ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : ptr + 1'b1;
    end
  endfunction

  assign wr_ready_out = (count_q != DEPTH[AW:0]);
  assign rd_valid_out = (count_q != {(AW+1){1'b0}});
  assign rd_data_out  = mem_q[rd_ptr_q];
  assign do_wr        = wr_valid_in & wr_ready_out;
  assign do_rd        = rd_valid_out & rd_ready_in;

  always @(posedge mclk_in) begin
    if (do_wr) begin
      mem_q[wr_ptr_q] <= wr_data_in;
    end
    if (rst_in) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_q <= next_ptr(wr_ptr_q);
      end
      if (do_rd) begin
        rd_ptr_q <= next_ptr(rd_ptr_q);
      end
      if (do_wr & ~do_rd) begin
        count_q <= count_q + 1'b1;
      end else if (do_rd & ~do_wr) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// file: logic/ssi_encoder_slave.v
`timescale 1ns/100ps
`include "ssi_encoder_map.vh"
// How it works
// RULE_01 - Two modes: position output and service setup
// RULE_02 - Position output mode entered after reset
// RULE_03 - Master clocks the link, device returns data
// RULE_04 - Self-test reports critical sensing abnormality
// RULE_05 - Error flag 0 normal, 1 on error
// RULE_06 - No self-test option means no flag bit
// RULE_07 - Position refreshed at 35 kHz, optional 375
// RULE_08 - Master spaces requests, pause 26 us minimum
// RULE_09 - Setup mode reuses clock and data pairs
// RULE_10 - Latch on first fall, shift MSB first on rises
// RULE_11 - Data low for monoflop time, then high
module ssi_encoder_slave #(
  parameter POS_BITS       = `POS_BITS,
  parameter HAS_SELF_TEST  = 1,
  parameter FAST_UPDATE    = 0,
  parameter RELEASE_CYCLES = `LINE_RELEASE_CYCLES
) (
  input  wire                mclk_in,
  input  wire                rst_in,
  input  wire [POS_BITS-1:0] position_in,
  input  wire                sense_fault_in,
  input  wire                setup_mode_in,
  input  wire                ssi_clk_in,
  output reg                 ssi_data_out,
  output reg                 ssi_data_oe_n_out,
  output reg                 setup_rx_out,
  input  wire                setup_tx_in,
  output reg                 setup_active_out,
  output reg                 fifo_overflow_out
);
  // ----------------------------------------
  // Constants and states
  // ----------------------------------------
  localparam UPD_CYC   = FAST_UPDATE ? `UPDATE_FAST_CYCLES : `UPDATE_CYCLES;
  localparam FRAME_LEN = POS_BITS + (HAS_SELF_TEST ? 1 : 0);
  localparam FW        = POS_BITS + 1;
  localparam S_IDLE    = 4'h1;
  localparam S_SHIFT   = 4'h2;
  localparam S_MONO    = 4'h4;
  localparam S_SETUP   = 4'h8;

  function timer_expired;
    input [19:0] count;
    begin
      timer_expired = (count == RELEASE_CYCLES[19:0] - 20'h00001);
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg        clk_s1_q;
  reg        clk_s2_q;
  reg        clk_s3_q;
  reg        tx_s1_q;
  reg        tx_s2_q;
  reg        mode_s1_q;
  reg        mode_s2_q;
  wire       clk_fall;
  wire       clk_rise;

  always @(posedge mclk_in) begin
    if (rst_in) begin
      clk_s1_q  <= 1'b1;
      clk_s2_q  <= 1'b1;
      clk_s3_q  <= 1'b1;
      tx_s1_q   <= 1'b1;
      tx_s2_q   <= 1'b1;
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
    end else begin
      clk_s1_q  <= ssi_clk_in;
      clk_s2_q  <= clk_s1_q;
      clk_s3_q  <= clk_s2_q;
      tx_s1_q   <= setup_tx_in;
      tx_s2_q   <= tx_s1_q;
      mode_s1_q <= setup_mode_in;
      mode_s2_q <= mode_s1_q;
    end
  end

  assign clk_fall = clk_s3_q & ~clk_s2_q;
  assign clk_rise = ~clk_s3_q & clk_s2_q;

  // ----------------------------------------
  // Position sampling into the buffer
  // ----------------------------------------
  // Sampler writes at the update rate; the frame logic drains to the freshest word
  reg  [15:0]     upd_cnt_q;
  wire            upd_tick;
  wire            fifo_wr_ready;
  wire            fifo_rd_valid;
  wire [FW-1:0]   fifo_rd_data;
  reg  [FW-1:0]   sample_d;
  reg  [FW-1:0]   latest_q;

  assign upd_tick = (upd_cnt_q == UPD_CYC[15:0] - 16'h0001);

  always @* begin
    sample_d = {position_in, sense_fault_in ? `ERR_FLAG_FAIL : `ERR_FLAG_OK}; // see RULE_04
  end

  always @(posedge mclk_in) begin
    if (rst_in) begin
      upd_cnt_q <= 16'h0000;
    end else if (upd_tick) begin
      upd_cnt_q <= 16'h0000; // see RULE_07
    end else begin
      upd_cnt_q <= upd_cnt_q + 16'h0001;
    end
  end

  sample_fifo #(
    .WIDTH (FW),
    .DEPTH (`FIFO_DEPTH),
    .AW    (5)
  ) sample_fifo_inst (
    .mclk_in      (mclk_in),
    .rst_in       (rst_in),
    .wr_valid_in  (upd_tick),
    .wr_ready_out (fifo_wr_ready),
    .wr_data_in   (sample_d),
    .rd_valid_out (fifo_rd_valid),
    .rd_ready_in  (1'b1),
    .rd_data_out  (fifo_rd_data)
  );

  // ----------------------------------------
  // Frame state machine
  // ----------------------------------------
  reg  [3:0]          state_q;
  reg  [FW-1:0]       shift_q;
  reg  [5:0]          bit_cnt_q;
  reg  [19:0]         mono_cnt_q;

  always @(posedge mclk_in) begin
    if (rst_in) begin
      latest_q          <= {FW{1'b0}};
      fifo_overflow_out <= 1'b0;
    end else begin
      if (fifo_rd_valid) begin
        latest_q <= fifo_rd_data; // see RULE_07
      end
      if (upd_tick & ~fifo_wr_ready) begin
        fifo_overflow_out <= 1'b1;
      end
    end
  end

  always @(posedge mclk_in) begin
    if (rst_in) begin
      state_q           <= S_IDLE; // see RULE_02
      shift_q           <= {FW{1'b0}};
      bit_cnt_q         <= 6'h00;
      mono_cnt_q        <= 20'h00000;
      ssi_data_out      <= 1'b1;
      ssi_data_oe_n_out <= 1'b0;
      setup_rx_out      <= 1'b1;
      setup_active_out  <= 1'b0;
    end else begin
      setup_rx_out <= clk_s2_q; // see RULE_09
      case (state_q)
        S_IDLE: begin
          ssi_data_out     <= 1'b1;
          setup_active_out <= 1'b0;
          if (mode_s2_q) begin
            state_q <= S_SETUP; // see RULE_01
          end else if (clk_fall) begin
            // Slave starts a frame only on the master's clock fall
            shift_q    <= latest_q; // see RULE_03 see RULE_10
            bit_cnt_q  <= 6'h00;
            mono_cnt_q <= 20'h00000;
            state_q    <= S_SHIFT;
          end
        end
        S_SHIFT: begin
          if (clk_rise) begin
            mono_cnt_q <= 20'h00000;
            if (bit_cnt_q == FRAME_LEN[5:0]) begin
              // Extra rise after last bit: frame over
              ssi_data_out <= 1'b0; // see RULE_11
              state_q      <= S_MONO;
            end else begin
              ssi_data_out <= shift_q[FW-1]; // see RULE_10 see RULE_05 see RULE_06
              shift_q      <= {shift_q[FW-2:0], 1'b0};
              bit_cnt_q    <= bit_cnt_q + 6'h01;
            end
          end else if (clk_fall) begin
            mono_cnt_q <= 20'h00000;
          end else if (timer_expired(mono_cnt_q)) begin
            // A master that stops mid-frame would otherwise leave the line stuck
            ssi_data_out <= 1'b1; // see RULE_11
            state_q      <= S_IDLE;
          end else begin
            mono_cnt_q <= mono_cnt_q + 20'h00001;
          end
        end
        S_MONO: begin
          ssi_data_out <= 1'b0;
          // Clock edges restart the timeout, so a stopped clock is needed for release
          if (clk_fall | clk_rise) begin
            mono_cnt_q <= 20'h00000; // see RULE_08
          end else if (timer_expired(mono_cnt_q)) begin
            ssi_data_out <= 1'b1; // see RULE_11
            state_q      <= S_IDLE;
          end else begin
            mono_cnt_q <= mono_cnt_q + 20'h00001;
          end
        end
        S_SETUP: begin
          setup_active_out <= 1'b1;
          ssi_data_out     <= tx_s2_q; // see RULE_09
          if (~mode_s2_q) begin
            state_q <= S_IDLE; // see RULE_01
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// file: testbench/ssi_encoder_slave_monitor.sv
`timescale 1ns/100ps
// ----
// Link checks
// ----
module ssi_encoder_slave_monitor #(
  parameter POS_BITS = 16,
  parameter HAS_SELF_TEST = 1,
  parameter RELEASE_CYCLES = 625
) (
  input wire mclk_in,
  input wire rst_in,
  input wire [POS_BITS-1:0] position_in,
  input wire sense_fault_in,
  input wire setup_mode_in,
  input wire ssi_clk_in,
  input wire ssi_data_out,
  input wire ssi_data_oe_n_out,
  input wire setup_rx_out,
  input wire setup_tx_in,
  input wire setup_active_out,
  input wire fifo_overflow_out
);
  localparam NB = POS_BITS + HAS_SELF_TEST;
  reg clk_q;
  reg [11:0] quiet_q;
  reg [3:0] since_q;
  reg [5:0] rises_q;
  wire rise = ssi_clk_in & ~clk_q;
  // Frame count clears once the link has been quiet longer than a bit time
  always @(posedge mclk_in) begin
    clk_q <= ssi_clk_in;
    if (rst_in) begin
      quiet_q <= 12'h000;
      since_q <= 4'hF;
      rises_q <= 6'h00;
    end else begin
      quiet_q <= (ssi_clk_in != clk_q) ? 12'h000 : quiet_q + {11'h000, quiet_q != 12'hFFF};
      since_q <= rise ? 4'h0 : since_q + {3'h0, since_q != 4'hF};
      rises_q <= (quiet_q > 12'h00C) ? 6'h00 : rises_q + {5'h00, rise};
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  property p_oe; ssi_data_oe_n_out == 1'b0; endproperty
  property p_reset; disable iff (1'b0) rst_in |=> ssi_data_out && !setup_active_out; endproperty
  property p_mode; !setup_mode_in [*8] |-> !setup_active_out; endproperty
  property p_tx; (setup_active_out && !setup_tx_in) [*6] |-> !ssi_data_out; endproperty
  property p_rx; (setup_active_out && !ssi_clk_in) [*6] |-> !setup_rx_out; endproperty
  property p_release; quiet_q == RELEASE_CYCLES + 8 && !setup_active_out |-> ssi_data_out;
  endproperty
  property p_tail; rise && rises_q == NB |-> ##6 (!ssi_data_out) [*4]; endproperty
  property p_cause;
    $changed(ssi_data_out) && !setup_mode_in && !setup_active_out && !$past(setup_active_out, 4)
      |-> since_q inside {[1:6]} || quiet_q >= RELEASE_CYCLES;
  endproperty
  property p_ovf; !fifo_overflow_out; endproperty
  a_oe: assert property (p_oe) else $error("data driver off");
  a_reset: assert property (p_reset) else $error("bad reset state");
  a_mode: assert property (p_mode) else $error("setup without pin");
  a_tx: assert property (p_tx) else $error("setup data wrong");
  a_rx: assert property (p_rx) else $error("setup receive wrong");
  a_release: assert property (p_release) else $error("line not released");
  a_tail: assert property (p_tail) else $error("tail not low");
  a_cause: assert property (p_cause) else $error("data moved unclocked");
  a_ovf: assert property (p_ovf) else $error("sample buffer overflow");
  c_tail: cover property (rise && rises_q == NB);
  c_setup: cover property (setup_active_out);
  c_release: cover property (quiet_q == RELEASE_CYCLES + 8);
endmodule

// file: testbench/ssi_master_model.sv
`timescale 1ns/100ps
// ----
// Link master
// ----
module ssi_master_model (
  input wire data_in,
  output reg ssi_clk_out
);
  initial ssi_clk_out = 1'b1; // Clock stands high outside frames
  task drive(input logic v);
    ssi_clk_out = v;
  endtask
  // Samples just before each rise after the first, well clear of the slave's sync delay
  task read_frame(input int nb, output logic [31:0] word, output logic tail, output logic rel);
    word = 32'h0;
    ssi_clk_out = 1'b0;
    #160;
    for (int k = 1; k <= nb + 1; k++) begin
      if (k > 1) word = {word[30:0], data_in};
      ssi_clk_out = 1'b1;
      #160;
      if (k <= nb) ssi_clk_out = 1'b0;
      #160;
    end
    tail = data_in;
    #26000;
    rel = data_in;
  endtask
endmodule

// file: testbench/absolute_encoder_ssi_slave_tb.sv
`timescale 1ns/100ps
// ----
// Bench top
// ----
module absolute_encoder_ssi_slave_tb;
  localparam POS_BITS = 16;
  localparam HAS_SELF_TEST = 1;
  localparam RELEASE_CYCLES = 16;
  reg mclk_in, rst_in, sense_fault_in, setup_mode_in, setup_tx_in;
  reg [15:0] position_in;
  wire ssi_clk_in, ssi_data_out, ssi_data_oe_n_out, setup_rx_out, setup_active_out;
  wire fifo_overflow_out;
  wire data_plain;
  reg [31:0] word_plain;
  wire line = ssi_data_oe_n_out ? 1'b1 : ssi_data_out; // Pull-up when released
  int err_total = 0;
  int tests_run = 0;
  ssi_encoder_slave #(.POS_BITS(POS_BITS), .HAS_SELF_TEST(HAS_SELF_TEST), .FAST_UPDATE(1),
    .RELEASE_CYCLES(RELEASE_CYCLES)) ssi_encoder_slave_inst (
    .mclk_in(mclk_in), .rst_in(rst_in), .position_in(position_in),
    .sense_fault_in(sense_fault_in), .setup_mode_in(setup_mode_in), .ssi_clk_in(ssi_clk_in),
    .ssi_data_out(ssi_data_out), .ssi_data_oe_n_out(ssi_data_oe_n_out),
    .setup_rx_out(setup_rx_out), .setup_tx_in(setup_tx_in),
    .setup_active_out(setup_active_out), .fifo_overflow_out(fifo_overflow_out));
  ssi_master_model ssi_master_model_inst (.data_in(line), .ssi_clk_out(ssi_clk_in));
  // Variant without self-test listens on the same clock; setup mode stays off
  ssi_encoder_slave #(.POS_BITS(POS_BITS), .HAS_SELF_TEST(0), .FAST_UPDATE(1),
    .RELEASE_CYCLES(RELEASE_CYCLES)) ssi_encoder_slave_plain_inst (
    .mclk_in(mclk_in), .rst_in(rst_in), .position_in(position_in),
    .sense_fault_in(sense_fault_in), .setup_mode_in(1'b0), .ssi_clk_in(ssi_clk_in),
    .ssi_data_out(data_plain), .ssi_data_oe_n_out(), .setup_rx_out(), .setup_tx_in(1'b1),
    .setup_active_out(), .fifo_overflow_out());
  // Value standing just before each master rise
  always @(posedge ssi_clk_in) word_plain <= {word_plain[30:0], data_plain};
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task t_idle;
    check("data", 32'h1, {31'h0, ssi_data_out});
    check("setup", 32'h0, {31'h0, setup_active_out});
    check("overflow", 32'h0, {31'h0, fifo_overflow_out});
  endtask
  // Wait covers over two refresh periods (150 cycles against 66) so the frame shows the new word
  task t_frame(input logic [15:0] pos, input logic fault);
    logic [31:0] word;
    logic tail, rel;
    position_in = pos;
    sense_fault_in = fault;
    cyc(150);
    ssi_master_model_inst.read_frame(17, word, tail, rel);
    check("word", {15'h0, pos, fault}, word);
    check("plain word", {14'h0, 1'b1, pos, 1'b0}, {14'h0, word_plain[17:0]});
    check("tail", 32'h0, {31'h0, tail});
    check("release", 32'h1, {31'h0, rel});
  endtask
  // Master stops after two bits; both variants must give the line back
  task t_cut;
    repeat (2) begin
      ssi_master_model_inst.drive(1'b0);
      cyc(4);
      ssi_master_model_inst.drive(1'b1);
      cyc(4);
    end
    cyc(RELEASE_CYCLES + 12);
    check("cut line", 32'h1, {31'h0, line});
    check("cut plain line", 32'h1, {31'h0, data_plain});
    cyc(650);
  endtask
  task t_setup;
    int n;
    setup_mode_in = 1'b1;
    setup_tx_in = 1'b0;
    n = 0;
    while (setup_active_out !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    if (setup_active_out !== 1'b1) begin
      err_total++;
      tally_and_finish;
    end
    cyc(8);
    check("tx low", 32'h0, {31'h0, ssi_data_out});
    setup_tx_in = 1'b1;
    cyc(8);
    check("tx high", 32'h1, {31'h0, ssi_data_out});
    ssi_master_model_inst.drive(1'b0);
    cyc(8);
    check("rx low", 32'h0, {31'h0, setup_rx_out});
    ssi_master_model_inst.drive(1'b1);
    cyc(8);
    check("rx high", 32'h1, {31'h0, setup_rx_out});
    setup_mode_in = 1'b0;
    cyc(12);
    t_idle;
  endtask
  initial begin
    rst_in = 1'b1;
    position_in = 16'h0000;
    sense_fault_in = 1'b0;
    setup_mode_in = 1'b0;
    setup_tx_in = 1'b1;
    cyc(4);
    rst_in = 1'b0;
    cyc(3);
    t_idle;
    t_frame(16'hA5C3, 1'b0);
    t_cut;
    t_frame(16'h8001, 1'b1);
    t_frame(16'h7FFE, 1'b1);
    t_setup;
    t_frame(16'hFFFF, 1'b0);
    rst_in = 1'b1;
    cyc(4);
    rst_in = 1'b0;
    cyc(3);
    t_idle;
    tally_and_finish;
  end
endmodule
bind ssi_encoder_slave ssi_encoder_slave_monitor #(.POS_BITS(POS_BITS),
  .HAS_SELF_TEST(HAS_SELF_TEST), .RELEASE_CYCLES(RELEASE_CYCLES)) ssi_encoder_slave_monitor_inst (
  .mclk_in(mclk_in), .rst_in(rst_in), .position_in(position_in),
  .sense_fault_in(sense_fault_in), .setup_mode_in(setup_mode_in), .ssi_clk_in(ssi_clk_in),
  .ssi_data_out(ssi_data_out), .ssi_data_oe_n_out(ssi_data_oe_n_out),
  .setup_rx_out(setup_rx_out), .setup_tx_in(setup_tx_in),
  .setup_active_out(setup_active_out), .fifo_overflow_out(fifo_overflow_out));
